// >>> logic/irq_defs.svh
// Register indices, bit positions, reset values and vectors of the interrupt logic.
`ifndef IRQ_DEFS_SVH
`define IRQ_DEFS_SVH
`define REQ_INDEX        6'h16
`define ENA_INDEX        6'h17
`define CORE_CTRL_INDEX  6'h07
`define CPU_STATUS_INDEX 6'h06
`define CORE_SUMMARY_BIT 7
`define CORE_TCK_FLAG    6
`define CORE_T0_FLAG     5
`define CORE_EXT_FLAG    4
`define CORE_PGE_BIT     3
`define CORE_TCK_EN      2
`define CORE_T0_EN       1
`define CORE_EXT_EN      0
`define CPU_GDIS_BIT     4
`define REQ_TX_BIT       1
`define REQ_RX_BIT       0
`define ENA_RESET        8'h00
`define REQ_FLAGS_RESET  6'h00
`define CORE_FLAGS_RESET 3'h0
`define CORE_EN_RESET    4'h0
`define TX_FLAG_RESET    1'b1
`define RX_FLAG_RESET    1'b0
`define GDIS_RESET       1'b1
`define VEC_EXT          16'h0008
`define VEC_T0           16'h0010
`define VEC_TCK          16'h0018
`define VEC_PERIPH       16'h0020
`define VEC_NONE         16'h0000
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`endif

// >>> logic/irq_pkg.sv
// Types shared by the interrupt logic.
`default_nettype none
package irq_pkg;
    typedef enum logic [3:0] {
        SRC_NONE   = 4'h0,
        SRC_EXT    = 4'h1,
        SRC_T0     = 4'h2,
        SRC_TCK    = 4'h4,
        SRC_PERIPH = 4'h8
    } irq_source_e;
endpackage
`default_nettype wire

// >>> logic/irq_flag_bank.sv
// Bank of sticky event flags where a hardware set beats any clear.
`timescale 1ns/1ps
`default_nettype none
module irq_flag_bank #(
    parameter int          WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET = '0
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] set,
    input  wire logic [WIDTH-1:0] wr,
    input  wire logic [WIDTH-1:0] wr_val,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] next_q;

    // An event in the clearing cycle is kept, so no request is lost.
    always_comb begin
        next_q = (q & ~wr) | (wr_val & wr) | set;
    end

    // Plain register stage.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= RESET;
        end else begin
            q <= next_q;
        end
    end
endmodule
`default_nettype wire

// >>> logic/vectored_interrupt_logic.sv
// Interrupt flags, enables, priority vectoring and AXI4-Lite register slave.
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "irq_defs.svh"

// Summary of operation
// - Enable register: one bit per source.
// - Flags set regardless of enables or disable.
// - Port-B mismatch sets bit 7 flag.
// - Timer3 flag source follows capture1 mode.
// - Timer2 period rollover sets bit 5.
// - Timer1 flag source follows wide mode.
// - Capture events set bits 3 and 2.
// - Serial flags track buffers, read-only, reset 1/0.
// - Global disable blocks all interrupts.
// - Global disable is set after reset.
// - Peripheral needs group and own enable.
// - Core sources gated by own enables.
// - Accept sets disable, pushes, loads vector.
// - Return instruction clears global disable.
// - Highest priority pending vector wins.
// - Four vectors, fixed descending priority.
// - Summary flag is OR of flag AND enable.
// - Core flags cleared by vectoring; peripheral not.
module vectored_interrupt_logic (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic                 awvalid,
    output logic                      awready,
    input  wire logic [7:0]           awaddr,
    input  wire logic                 wvalid,
    output logic                      wready,
    input  wire logic [31:0]          wdata,
    input  wire logic [3:0]           wstrb,
    output logic                      bvalid,
    input  wire logic                 bready,
    output logic      [1:0]           bresp,
    input  wire logic                 arvalid,
    output logic                      arready,
    input  wire logic [7:0]           araddr,
    output logic                      rvalid,
    input  wire logic                 rready,
    output logic      [31:0]          rdata,
    output logic      [1:0]           rresp,
    input  wire logic                 ext_pin_event,
    input  wire logic                 timer0_overflow,
    input  wire logic                 timer_clock_pin_event,
    input  wire logic                 portb_mismatch,
    input  wire logic                 capture1_or_period_select,
    input  wire logic                 timer3_overflow,
    input  wire logic                 timer3_period_rollover,
    input  wire logic                 timer2_period_rollover,
    input  wire logic                 timer_pair_wide_mode,
    input  wire logic                 timer1_period_rollover,
    input  wire logic                 timer_pair_rollover,
    input  wire logic                 capture2_event,
    input  wire logic                 capture1_event,
    input  wire logic                 serial_tx_buffer_empty,
    input  wire logic                 serial_rx_buffer_full,
    input  wire logic                 core_irq_window,
    input  wire logic                 return_from_handler_instr,
    output logic                      vector_load,
    output logic      [15:0]          vector_addr,
    output irq_pkg::irq_source_e      taken_source,
    output logic                      global_irq_disable
);
    import irq_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Register bus decode.
    logic        wr_fire;
    logic        wr_lane0;
    logic        wr_req;
    logic        wr_ena;
    logic        wr_core;
    logic        wr_cpu;
    logic        wr_hit;
    logic        rd_fire;
    logic        rd_hit;
    logic [7:0]  rd_value;
    logic        next_bvalid;
    logic [1:0]  next_bresp;
    logic        next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0]  next_rresp;

    // Address and data are taken together, so a lone channel simply waits.
    assign wr_fire  = awvalid && wvalid && !bvalid;
    assign awready  = wr_fire;
    assign wready   = wr_fire;
    assign wr_lane0 = wr_fire && wstrb[0];
    assign wr_req   = wr_lane0 && awaddr == {`REQ_INDEX, 2'b00};
    assign wr_ena   = wr_lane0 && awaddr == {`ENA_INDEX, 2'b00};
    assign wr_core  = wr_lane0 && awaddr == {`CORE_CTRL_INDEX, 2'b00};
    assign wr_cpu   = wr_lane0 && awaddr == {`CPU_STATUS_INDEX, 2'b00};
    assign wr_hit   = awaddr == {`REQ_INDEX, 2'b00}
                   || awaddr == {`ENA_INDEX, 2'b00}
                   || awaddr == {`CORE_CTRL_INDEX, 2'b00}
                   || awaddr == {`CPU_STATUS_INDEX, 2'b00};
    assign rd_fire  = arvalid && !rvalid;
    assign arready  = !rvalid;

    ////////////////////////////////////////////////////////////////////////
    // Flags, enables and serial status.
    logic [7:0]  ena;
    logic [3:0]  core_en;
    logic [5:0]  req_flags;
    logic [5:0]  req_set;
    logic [2:0]  core_flags;
    logic [2:0]  core_set;
    logic [2:0]  core_wr;
    logic [2:0]  core_val;
    logic        tx_flag;
    logic        rx_flag;
    logic [7:0]  req_view;
    logic        summary;
    logic [7:0]  core_view;
    logic [7:0]  next_ena;
    logic [3:0]  next_core_en;
    logic        accept;
    irq_source_e vector_pick;

    // Event sources; timer modes pick which event counts.
    always_comb begin
        req_set[5] = portb_mismatch;
        req_set[4] = capture1_or_period_select ? timer3_overflow
                                               : timer3_period_rollover;
        req_set[3] = timer2_period_rollover;
        req_set[2] = timer_pair_wide_mode ? timer_pair_rollover
                                          : timer1_period_rollover;
        req_set[1] = capture2_event;
        req_set[0] = capture1_event;
        core_set   = {timer_clock_pin_event, timer0_overflow,
                      ext_pin_event};
    end

    // Peripheral flags latch even while masked; serial bits are not here.
    irq_flag_bank #(
        .WIDTH (6),
        .RESET (`REQ_FLAGS_RESET)
    ) i_irq_flag_bank (
        .aclk    (aclk),
        .aresetn (aresetn),
        .set     (req_set),
        .wr      ({6{wr_req}}),
        .wr_val  (wdata[7:2]),
        .q       (req_flags)
    );

    // Core flags: software write or hardware clear on vectoring.
    always_comb begin
        core_wr  = {3{wr_core}};
        core_val = wdata[`CORE_TCK_FLAG:`CORE_EXT_FLAG];
        if (vector_pick != SRC_NONE && accept) begin
            core_wr  = core_wr | vector_pick[2:0];
            core_val = core_val & ~vector_pick[2:0];
        end
    end

    irq_flag_bank #(
        .WIDTH (3),
        .RESET (`CORE_FLAGS_RESET)
    ) i_irq_flag_bank_core (
        .aclk    (aclk),
        .aresetn (aresetn),
        .set     (core_set),
        .wr      (core_wr),
        .wr_val  (core_val),
        .q       (core_flags)
    );

    // Enable registers take software writes only.
    always_comb begin
        next_ena     = wr_ena ? wdata[7:0] : ena;
        next_core_en = wr_core ? wdata[`CORE_PGE_BIT:`CORE_EXT_EN]
                               : core_en;
    end

    // Serial levels are resampled so reset shows the documented values.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ena     <= `ENA_RESET;
            core_en <= `CORE_EN_RESET;
            tx_flag <= `TX_FLAG_RESET;
            rx_flag <= `RX_FLAG_RESET;
        end else begin
            ena     <= next_ena;
            core_en <= next_core_en;
            tx_flag <= serial_tx_buffer_empty;
            rx_flag <= serial_rx_buffer_full;
        end
    end

    assign req_view  = {req_flags, tx_flag, rx_flag};
    assign summary   = |(req_view & ena);
    assign core_view = {summary, core_flags, core_en};

    ////////////////////////////////////////////////////////////////////////
    // Priority selection and vectoring.
    logic [15:0] pick_addr;
    logic        next_vector_load;
    logic [15:0] next_vector_addr;
    irq_source_e next_taken_source;
    logic        next_gdis;

    // Fixed priority: external pin, timer0, clock pin, then peripherals.
    always_comb begin
        vector_pick = SRC_NONE;
        pick_addr   = `VEC_NONE;
        if (core_flags[0] && core_en[`CORE_EXT_EN]) begin
            vector_pick = SRC_EXT;
            pick_addr   = `VEC_EXT;
        end else if (core_flags[1] && core_en[`CORE_T0_EN]) begin
            vector_pick = SRC_T0;
            pick_addr   = `VEC_T0;
        end else if (core_flags[2] && core_en[`CORE_TCK_EN]) begin
            vector_pick = SRC_TCK;
            pick_addr   = `VEC_TCK;
        end else if (summary && core_en[`CORE_PGE_BIT]) begin
            vector_pick = SRC_PERIPH;
            pick_addr   = `VEC_PERIPH;
        end
    end

    // Only at an instruction boundary and with interrupts allowed.
    assign accept = core_irq_window && !global_irq_disable
                 && vector_pick != SRC_NONE;

    // Accepting beats both the return and a software clear of the disable.
    always_comb begin
        next_vector_load  = accept;
        next_taken_source = accept ? vector_pick : SRC_NONE;
        next_vector_addr  = accept ? pick_addr : vector_addr;
        next_gdis         = global_irq_disable;
        if (accept) begin
            next_gdis = 1'b1;
        end else if (return_from_handler_instr) begin
            next_gdis = 1'b0;
        end else if (wr_cpu) begin
            next_gdis = wdata[`CPU_GDIS_BIT];
        end
    end

    // The vector address holds its last value between accepts.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vector_load        <= 1'b0;
            vector_addr        <= `VEC_NONE;
            taken_source       <= SRC_NONE;
            global_irq_disable <= `GDIS_RESET;
        end else begin
            vector_load        <= next_vector_load;
            vector_addr        <= next_vector_addr;
            taken_source       <= next_taken_source;
            global_irq_disable <= next_gdis;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Response channels.
    always_comb begin
        unique case (araddr)
            {`REQ_INDEX, 2'b00}:        rd_value = req_view;
            {`ENA_INDEX, 2'b00}:        rd_value = ena;
            {`CORE_CTRL_INDEX, 2'b00}:  rd_value = core_view;
            {`CPU_STATUS_INDEX, 2'b00}: rd_value =
                8'({global_irq_disable, 4'h0});
            default:                    rd_value = 8'h00;
        endcase
        rd_hit = araddr == {`REQ_INDEX, 2'b00}
              || araddr == {`ENA_INDEX, 2'b00}
              || araddr == {`CORE_CTRL_INDEX, 2'b00}
              || araddr == {`CPU_STATUS_INDEX, 2'b00};
        next_bvalid = bvalid ? !bready : wr_fire;
        next_bresp  = wr_fire ? (wr_hit ? `RESP_OKAY : `RESP_SLVERR)
                              : bresp;
        next_rvalid = rvalid ? !rready : rd_fire;
        next_rdata  = rd_fire ? {24'h000000, rd_value} : rdata;
        next_rresp  = rd_fire ? (rd_hit ? `RESP_OKAY : `RESP_SLVERR)
                              : rresp;
    end

    // Answers are registered; unmapped addresses answer with an error.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= `RESP_OKAY;
            rvalid <= 1'b0;
            rdata  <= 32'h00000000;
            rresp  <= `RESP_OKAY;
        end else begin
            bvalid <= next_bvalid;
            bresp  <= next_bresp;
            rvalid <= next_rvalid;
            rdata  <= next_rdata;
            rresp  <= next_rresp;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks of the behaviour above.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_gdis_after_reset: assert property (
        $rose(aresetn) |-> global_irq_disable)
        else $error("Global disable not set after reset.");
    a_take_sets_gdis: assert property (
        vector_load |-> global_irq_disable && !$past(global_irq_disable))
        else $error("Vector load without disable handover.");
    a_masked_no_take: assert property (
        global_irq_disable && !return_from_handler_instr && !wr_cpu
        |=> !vector_load)
        else $error("Interrupt taken while globally disabled.");
    a_return_clears: assert property (
        return_from_handler_instr && !accept |=> !global_irq_disable)
        else $error("Return did not clear global disable.");
    a_ext_wins: assert property (
        accept && core_flags[0] && core_en[`CORE_EXT_EN]
        |=> vector_addr == `VEC_EXT && taken_source == SRC_EXT)
        else $error("Highest priority vector not chosen.");
    a_periph_gate: assert property (
        vector_load && taken_source == SRC_PERIPH
        |-> $past(core_en[`CORE_PGE_BIT]) && $past(summary))
        else $error("Peripheral taken without both enables.");
    a_flag_when_masked: assert property (
        capture1_event && ena == 8'h00 |=> req_flags[0])
        else $error("Masked capture event was lost.");
    a_portb_sets: assert property (
        portb_mismatch |=> req_view[7] [*1])
        else $error("Port-B change flag not set.");
    a_t0_hw_clear: assert property (
        accept && vector_pick == SRC_T0 && !timer0_overflow
        |=> !core_flags[1] && vector_addr == `VEC_T0)
        else $error("Timer0 flag not cleared on vectoring.");
    a_serial_tracks: assert property (
        ##1 tx_flag == $past(serial_tx_buffer_empty)
        && rx_flag == $past(serial_rx_buffer_full))
        else $error("Serial flags do not track buffers.");
    a_ena_write: assert property (
        wr_ena |=> ena == $past(wdata[7:0]))
        else $error("Enable register write lost.");

    c_ext_taken: cover property (vector_load && taken_source == SRC_EXT);
    c_periph_taken: cover property (
        vector_load && taken_source == SRC_PERIPH);
    c_return: cover property (
        vector_load ##[1:50] return_from_handler_instr);
    c_set_vs_clear: cover property (wr_req && portb_mismatch);
endmodule
`default_nettype wire

// >>> bench/core_model.sv
// Behavioural processor core: instruction window, stack depth, handler return.
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       slow,
    input  wire logic [3:0] hold,
    input  wire logic       vector_load,
    output logic            window,
    output logic            ret,
    output logic      [4:0] depth
);
    logic [3:0] left;
    logic       busy;
    logic       phase;

    ////////////////////////////////////////////////////////////////////////
    // A handler stays busy for hold+1 cycles, then the return pulse pops the stack.
    always @(posedge aclk) begin
        phase <= ~phase;
        ret   <= 1'b0;
        if (!aresetn) begin
            busy  <= 1'b0;
            depth <= 5'h00;
            phase <= 1'b0;
        end else if (vector_load) begin
            busy  <= 1'b1;
            left  <= hold;
            depth <= depth + 5'h01;
        end else if (busy && left != 4'h0) begin
            left <= left - 4'h1;
        end else if (busy) begin
            busy  <= 1'b0;
            ret   <= 1'b1;
            depth <= depth - 5'h01;
        end
    end

    // A slow core reaches a boundary only every other cycle, which shifts
    // the moment of acceptance without changing the outcome.
    assign window = !busy && (!slow || phase);
endmodule
`default_nettype wire

// >>> bench/vectored_interrupt_logic_tb_top.sv
// Self-checking testbench of the vectored interrupt logic.
`timescale 1ns/1ps
`default_nettype none
module vectored_interrupt_logic_tb_top;
    import irq_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [10:0] ev = 11'h000;
    logic        sel = 1'b0, wide = 1'b0, tx = 1'b1, rx = 1'b0;
    logic        slow = 1'b0;
    logic [3:0]  hold = 4'h8;
    wire logic   awready, wready, bvalid, arready, rvalid, vld, gdis;
    wire logic   win, ret;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [15:0] vaddr;
    wire logic [4:0]  depth;
    irq_source_e      src;
    logic [31:0] q[$];
    logic [31:0] r;
    logic [7:0]  d, e, f;
    int miscompares = 0, n_tests = 0, cycles = 0;
    int evi[10] = '{3, 4, 5, 4, 6, 7, 8, 8, 9, 10};
    int slv[10] = '{0, 1, 0, 0, 0, 0, 0, 0, 0, 0};
    int wdv[10] = '{0, 0, 0, 0, 0, 0, 1, 0, 0, 0};
    int bit_of[10] = '{7, 6, 6, -1, 5, 4, 4, -1, 3, 2};

    vectored_interrupt_logic i_vectored_interrupt_logic (
        .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
        .wready(wready), .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid),
        .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp),
        .ext_pin_event(ev[0]), .timer0_overflow(ev[1]),
        .timer_clock_pin_event(ev[2]), .portb_mismatch(ev[3]),
        .capture1_or_period_select(sel), .timer3_overflow(ev[4]),
        .timer3_period_rollover(ev[5]), .timer2_period_rollover(ev[6]),
        .timer_pair_wide_mode(wide), .timer1_period_rollover(ev[7]),
        .timer_pair_rollover(ev[8]), .capture2_event(ev[9]),
        .capture1_event(ev[10]), .serial_tx_buffer_empty(tx),
        .serial_rx_buffer_full(rx), .core_irq_window(win),
        .return_from_handler_instr(ret), .vector_load(vld),
        .vector_addr(vaddr), .taken_source(src),
        .global_irq_disable(gdis));

    core_model i_core_model (
        .aclk(aclk), .aresetn(aresetn), .slow(slow), .hold(hold),
        .vector_load(vld), .window(win), .ret(ret), .depth(depth));

    ////////////////////////////////////////////////////////////////////////
    // Clock, cycle ceiling, and a log of every vector the core is handed.
    always #5 aclk = ~aclk;
    always @(posedge aclk) begin
        cycles++;
        if (vld === 1'b1) begin
            q.push_back({11'h0, gdis, src, vaddr});
        end
        if (cycles == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    function automatic logic [1:0] resp_for(input logic [7:0] a);
        return (a == 8'h58 || a == 8'h5c || a == 8'h18 || a == 8'h1c) ?
            2'h0 : 2'h2;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t value %h expected %h", $time, got, exp);
        end
    endtask

    // Waits for the next logged vector; disable must already be set.
    task automatic take(input logic [15:0] va, input irq_source_e s);
        int n;
        n = 0;
        slow <= 1'($urandom % 2);
        hold <= 4'(8 + $urandom % 8);
        while (q.size() == 0 && n < 80) begin
            @(posedge aclk);
            n++;
        end
        n_tests++;
        if (q.size() == 0 || q[0] !== {11'h0, 1'b1, s, va}) begin
            miscompares++;
            $display("BAD %0t vector missing or wrong, want %h", $time, va);
        end
        if (q.size() != 0) begin
            void'(q.pop_front());
        end
    endtask

    task automatic no_vec(input int n);
        repeat (n) @(posedge aclk);
        chk(32'(q.size()), 32'h0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        awaddr  <= a;
        wdata   <= {24'h000000, v};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do @(posedge aclk); while (!(awready && wready));
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        do @(posedge aclk); while (bvalid !== 1'b1);
        chk(32'(bresp), 32'(resp_for(a)));
        bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] v);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        chk(32'(rresp), 32'(resp_for(a)));
        chk(rdata, {24'h000000, v});
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic pulse(input logic [10:0] m);
        ev <= m;
        @(posedge aclk);
        ev <= 11'h000;
        @(posedge aclk);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence: reset values, register access, events, vectoring.
    initial begin
        void'($urandom(79898));
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk(32'(gdis), 32'h1);
        rdc(8'h58, 8'h02);
        rdc(8'h5c, 8'h00);
        rdc(8'h18, 8'h10);
        rdc(8'h1c, 8'h00);
        rdc(8'h40, 8'h00);
        wr(8'h40, 8'hff);
        for (int i = 0; i < 6; i++) begin
            d = 8'($urandom);
            e = (i == 0) ? 8'hff : 8'($urandom);
            tx <= 1'($urandom % 2);
            rx <= 1'($urandom % 2);
            wr(8'h58, d);
            wr(8'h5c, e);
            f = (d & 8'hfc) | {6'h00, tx, rx};
            rdc(8'h5c, e);
            rdc(8'h58, f);
            rdc(8'h1c, {|(f & e), 7'h00});
        end
        // Every peripheral source with every enable off and interrupts disabled.
        wr(8'h5c, 8'h00);
        for (int i = 0; i < 10; i++) begin
            sel  <= 1'(slv[i]);
            wide <= 1'(wdv[i]);
            wr(8'h58, 8'h00);
            pulse(11'(1 << evi[i]));
            f = (bit_of[i] < 0) ? 8'h00 : 8'(1 << bit_of[i]);
            rdc(8'h58, f | {6'h00, tx, rx});
        end
        // Flags cleared before enabling, all four sources then pend at once.
        wr(8'h58, 8'h00);
        wr(8'h5c, 8'h80);
        wr(8'h1c, 8'h0f);
        pulse(11'h00f);
        no_vec(10);
        wr(8'h18, 8'h00);
        take(16'h0008, SRC_EXT);
        take(16'h0010, SRC_T0);
        take(16'h0018, SRC_TCK);
        take(16'h0020, SRC_PERIPH);
        take(16'h0020, SRC_PERIPH);
        wr(8'h58, 8'h00);
        no_vec(40);
        chk(32'(gdis), 32'h0);
        chk(32'(depth), 32'h0);
        // Group enable and own core enable off block their sources.
        wr(8'h1c, 8'h05);
        pulse(11'h00a);
        no_vec(20);
        rdc(8'h1c, 8'ha5);
        wr(8'h18, 8'h10);
        wr(8'h1c, 8'h2f); // Keeps the pending timer0 flag set.
        no_vec(20);
        wr(8'h18, 8'h00);
        take(16'h0010, SRC_T0);
        take(16'h0020, SRC_PERIPH);
        wr(8'h58, 8'h00);
        no_vec(40);
        tally_and_finish();
    end
endmodule
`default_nettype wire
